// File: src/pcv_phase_protect.sv
// Phase current sampling, balance, overcurrent hiccup and code decode.
// Assumes a phase-clock enable pulse and sense samples synchronous to core_clk.
// What this block does
// - One settled sample per phase per cycle
// - Per-phase samplers; phases three, four optional
// - Balance error: phase one versus mean
// - Mean above 75 uA shuts down at once
// - Shutdown releases every phase drive
// - Hold released for 2048 phase-clock cycles
// - Then soft-start with drives switching; success enters run
// - Failed soft-start repeats wait and retry
// - Hiccup has no retry limit
// - Five-bit code gives one level or off
// - All ones off; 1.550 V down in 25 mV
// - All-ones code shuts down, others restart
// - Soft-start timed by 11-bit phase-clock counter
// - Enabled, valid code starts soft-start immediately
`timescale 1ns/10ps
module pcv_phase_protect #(
    parameter int WAIT_COUNT = pcv_pkg::WAIT_CYCLES,
    parameter int SETTLE = pcv_pkg::SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ctrlEnable,
    input wire logic phaseClkEn,
    input wire logic [1:0] phaseMode,
    input wire logic [3:0] phaseCycleStart,
    input wire logic [pcv_pkg::SENSE_W-1:0] phaseCurrentSense0,
    input wire logic [pcv_pkg::SENSE_W-1:0] phaseCurrentSense1,
    input wire logic [pcv_pkg::SENSE_W-1:0] phaseCurrentSense2,
    input wire logic [pcv_pkg::SENSE_W-1:0] phaseCurrentSense3,
    input wire logic [3:0] phaseDrive,
    input wire logic [4:0] voltage_code_pins,
    output logic [3:0] driveOut,
    output logic [3:0] driveOutEn,
    output logic [pcv_pkg::SENSE_W-1:0] meanPhaseCurrent,
    output logic signed [pcv_pkg::SENSE_W:0] balanceError,
    output logic [10:0] referenceLevel,
    output logic codeOff,
    output logic softStartActive,
    output logic [10:0] softStartCount,
    output logic overCurrent
);
    localparam int SW = pcv_pkg::SENSE_W;

    // ****************************************
    // Functions
    // ****************************************
    // Code to level in mV: each count of code subtracts one step from the top level
    function automatic logic [10:0] code_to_mv(input logic [4:0] code);
        logic [10:0] steps;
        steps = {6'h00, code};
        code_to_mv = pcv_pkg::LEVEL_TOP_MV - 11'(steps * pcv_pkg::LEVEL_STEP_MV);
    endfunction

    // ****************************************
    // Per-phase sampling
    // ****************************************
    logic [3:0] phaseActive;
    logic [SW-1:0] samples [4];
    logic [SW-1:0] senseIn [4];

    // Reduced phase count parks the upper instances
    always_comb begin
        phaseActive = 4'hF;
        if (phaseMode == pcv_pkg::MODE_THREE) begin
            phaseActive = 4'h7;
        end else if (phaseMode == pcv_pkg::MODE_TWO) begin
            phaseActive = 4'h3;
        end
    end

    assign senseIn[0] = phaseCurrentSense0;
    assign senseIn[1] = phaseCurrentSense1;
    assign senseIn[2] = phaseCurrentSense2;
    assign senseIn[3] = phaseCurrentSense3;

    for (genvar p = 0; p < pcv_pkg::NUM_PHASES; p++) begin : g_phase
        pcv_phase_sampler #(
            .SETTLE(SETTLE)
        ) u_sampler (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .phaseActive(phaseActive[p]),
            .cycleStart(phaseCycleStart[p]),
            .phaseCurrentSense(senseIn[p]),
            .sample(samples[p])
        );
    end

    // ****************************************
    // Mean, balance error, overcurrent
    // ****************************************
    logic [SW+1:0] sampleSum;
    logic [SW+1:0] meanWide;
    logic [SW-1:0] mean_q, mean_d;
    logic signed [SW:0] balErr_q, balErr_d;
    logic overCurrent_q, overCurrent_d;

    // Divide by the active count; a constant divisor of 3 is cheap here
    always_comb begin
        sampleSum = {2'b00, samples[0]} + {2'b00, samples[1]}
                  + {2'b00, samples[2]} + {2'b00, samples[3]};
        if (phaseMode == pcv_pkg::MODE_TWO) begin
            meanWide = sampleSum >> 1;
        end else if (phaseMode == pcv_pkg::MODE_THREE) begin
            meanWide = sampleSum / (SW+2)'(3);
        end else begin
            meanWide = sampleSum >> 2;
        end
        mean_d = meanWide[SW-1:0];
        balErr_d = $signed({1'b0, samples[0]}) - $signed({1'b0, mean_d});
        overCurrent_d = (mean_d > pcv_pkg::OC_REF_UA);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mean_q <= '0;
            balErr_q <= '0;
            overCurrent_q <= 1'b0;
        end else begin
            mean_q <= mean_d;
            balErr_q <= balErr_d;
            overCurrent_q <= overCurrent_d;
        end
    end

    // ****************************************
    // Code decode
    // ****************************************
    logic [10:0] level_q, level_d;
    logic codeOff_q, codeOff_d;

    // Off code parks the level at zero so nothing downstream regulates
    always_comb begin
        codeOff_d = (voltage_code_pins == pcv_pkg::CODE_OFF);
        level_d = codeOff_d ? 11'h000 : code_to_mv(voltage_code_pins);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level_q <= 11'h000;
            codeOff_q <= 1'b1;
        end else begin
            level_q <= level_d;
            codeOff_q <= codeOff_d;
        end
    end

    // ****************************************
    // Hiccup sequencer
    // ****************************************
    pcv_pkg::pcv_state_t state_q, state_d;
    logic [11:0] waitCnt_q, waitCnt_d;
    logic [pcv_pkg::SS_CNT_W-1:0] ssCnt_q, ssCnt_d;
    logic startOk;

    // Comparator drives transitions directly so a trip is never delayed
    always_comb begin
        startOk = ctrlEnable && !codeOff_d;
        state_d = state_q;
        waitCnt_d = waitCnt_q;
        ssCnt_d = ssCnt_q;
        if (!startOk) begin
            state_d = pcv_pkg::ST_OFF;
            waitCnt_d = 12'h000;
            ssCnt_d = '0;
        end else begin
            case (state_q)
                pcv_pkg::ST_OFF: begin
                    state_d = pcv_pkg::ST_SOFT;
                    ssCnt_d = '0;
                end
                pcv_pkg::ST_SOFT: begin
                    if (overCurrent_d) begin
                        state_d = pcv_pkg::ST_WAIT;
                        waitCnt_d = 12'h000;
                    end else if (phaseClkEn) begin
                        ssCnt_d = ssCnt_q + {{(pcv_pkg::SS_CNT_W-1){1'b0}}, 1'b1};
                        if (&ssCnt_q) begin
                            state_d = pcv_pkg::ST_RUN;
                        end
                    end
                end
                pcv_pkg::ST_RUN: begin
                    if (overCurrent_d) begin
                        state_d = pcv_pkg::ST_WAIT;
                        waitCnt_d = 12'h000;
                    end
                end
                pcv_pkg::ST_WAIT: begin
                    // No retry counter exists, so the loop never gives up
                    if (phaseClkEn) begin
                        waitCnt_d = waitCnt_q + 12'h001;
                        if (waitCnt_q == 12'(WAIT_COUNT - 1)) begin
                            state_d = pcv_pkg::ST_SOFT;
                            ssCnt_d = '0;
                        end
                    end
                end
                default: begin
                    state_d = pcv_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= pcv_pkg::ST_OFF;
            waitCnt_q <= 12'h000;
            ssCnt_q <= '0;
        end else begin
            state_q <= state_d;
            waitCnt_q <= waitCnt_d;
            ssCnt_q <= ssCnt_d;
        end
    end

    // ****************************************
    // Drive outputs
    // ****************************************
    logic switching;
    logic [3:0] driveOut_q, driveOut_d;
    logic [3:0] driveEn_q, driveEn_d;

    // Released drives let the drivers turn both transistors off
    always_comb begin
        switching = (state_d == pcv_pkg::ST_SOFT) || (state_d == pcv_pkg::ST_RUN);
        driveEn_d = switching ? phaseActive : 4'h0;
        driveOut_d = phaseDrive & driveEn_d;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            driveOut_q <= 4'h0;
            driveEn_q <= 4'h0;
        end else begin
            driveOut_q <= driveOut_d;
            driveEn_q <= driveEn_d;
        end
    end

    assign driveOut = driveOut_q;
    assign driveOutEn = driveEn_q;
    assign meanPhaseCurrent = mean_q;
    assign balanceError = balErr_q;
    assign referenceLevel = level_q;
    assign codeOff = codeOff_q;
    assign softStartActive = (state_q == pcv_pkg::ST_SOFT);
    assign softStartCount = ssCnt_q;
    assign overCurrent = overCurrent_q;
endmodule

// File: src/pcv_phase_sampler.sv
// One phase's current sampler: one sample per switching cycle after settle.
// Assumes cycleStart marks the start of the low-side conduction interval.
`timescale 1ns/10ps
module pcv_phase_sampler #(
    parameter int SETTLE = pcv_pkg::SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic phaseActive,
    input wire logic cycleStart,
    input wire logic [pcv_pkg::SENSE_W-1:0] phaseCurrentSense,
    output logic [pcv_pkg::SENSE_W-1:0] sample
);
    logic [7:0] settleCnt_q, settleCnt_d;
    logic armed_q, armed_d;
    logic [pcv_pkg::SENSE_W-1:0] sample_q, sample_d;

    // Settle counter arms once per cycle, so exactly one sample is taken
    always_comb begin
        settleCnt_d = settleCnt_q;
        armed_d = armed_q;
        sample_d = sample_q;
        if (!phaseActive) begin
            armed_d = 1'b0;
            sample_d = '0;
        end else if (cycleStart) begin
            armed_d = 1'b1;
            settleCnt_d = 8'(SETTLE);
        end else if (armed_q) begin
            if (settleCnt_q > 8'h01) begin
                settleCnt_d = settleCnt_q - 8'h01;
            end else begin
                armed_d = 1'b0;
                sample_d = phaseCurrentSense;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            settleCnt_q <= 8'h00;
            armed_q <= 1'b0;
            sample_q <= '0;
        end else begin
            settleCnt_q <= settleCnt_d;
            armed_q <= armed_d;
            sample_q <= sample_d;
        end
    end

    assign sample = sample_q;
endmodule

// File: src/pcv_pkg.sv
// Shared constants of the phase-current protection and code-decode block.
// Assumes one 100 MHz clock and a digitised sense sample per phase.
package pcv_pkg;
    // ****************************************
    // Timing and widths
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int SENSE_W = 12;
    localparam int NUM_PHASES = 4;
    localparam int WAIT_CYCLES = 2048;
    localparam int SS_CNT_W = 11;
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [SENSE_W-1:0] OC_REF_UA = 12'h04B;
    // ****************************************
    // Code decode, level in millivolts
    // ****************************************
    localparam logic [4:0] CODE_OFF = 5'h1F;
    localparam logic [10:0] LEVEL_TOP_MV = 11'h60E;
    localparam logic [10:0] LEVEL_STEP_MV = 11'h019;
    // ****************************************
    // Modes and sequencer states
    // ****************************************
    localparam logic [1:0] MODE_FOUR = 2'h0;
    localparam logic [1:0] MODE_THREE = 2'h1;
    localparam logic [1:0] MODE_TWO = 2'h2;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_SOFT = 4'h2,
        ST_RUN = 4'h4,
        ST_WAIT = 4'h8
    } pcv_state_t;
endpackage

// File: testbench/pcv_driver_model.sv
// Behavioural stand-in for the external phase drivers and sense paths.
// Assumes a released phase conducts nothing, so its sense reads zero.
`timescale 1ns/10ps
module pcv_driver_model (
    input wire logic [3:0] driveOutEn,
    input wire logic [11:0] loadUa,
    input wire logic [11:0] skewUa,
    output logic [11:0] sense0,
    output logic [11:0] sense1,
    output logic [11:0] sense2,
    output logic [11:0] sense3
);
    // ****************************************
    // Sense currents
    // ****************************************
    // Phase n carries load plus n skew steps, so balance is visible
    always_comb begin
        sense0 = driveOutEn[0] ? loadUa : 12'h000;
        sense1 = driveOutEn[1] ? loadUa + skewUa : 12'h000;
        sense2 = driveOutEn[2] ? loadUa + skewUa + skewUa : 12'h000;
        sense3 = driveOutEn[3] ? loadUa + skewUa + skewUa + skewUa : 12'h000;
    end
endmodule

// File: testbench/pcv_phase_protect_assertions.sv
// Port-level checker for the phase protection and code-decode block.
// Assumes it is bound onto pcv_phase_protect; one clock, sync reset.
`timescale 1ns/10ps
module pcv_phase_protect_assertions (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ctrlEnable,
    input wire logic phaseClkEn,
    input wire logic [1:0] phaseMode,
    input wire logic [4:0] voltage_code_pins,
    input wire logic [3:0] driveOutEn,
    input wire logic [pcv_pkg::SENSE_W-1:0] meanPhaseCurrent,
    input wire logic [10:0] referenceLevel,
    input wire logic codeOff,
    input wire logic softStartActive,
    input wire logic [10:0] softStartCount,
    input wire logic overCurrent
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Trip edge, then the drives must stay released for 8 cycles
    sequence s_trip;
        $rose(overCurrent);
    endsequence
    sequence s_released;
        driveOutEn == 4'h0;
    endsequence
    // Reset edges are skipped because $past still sees the held code
    a_level_decode: assert property ($past(!sys_rst) |-> referenceLevel ==
        (($past(voltage_code_pins) == 5'h1F) ? 11'h000 :
        11'h60E - 11'h019 * {6'h00, $past(voltage_code_pins)}))
        else $error("level does not match code");
    a_off_flag: assert property ($past(!sys_rst) |->
        codeOff == ($past(voltage_code_pins) == 5'h1F)) else $error("off flag wrong");
    a_trip_compare: assert property (
        overCurrent == (meanPhaseCurrent > pcv_pkg::OC_REF_UA)) else $error("trip flag wrong");
    a_trip_release: assert property (s_trip |-> s_released [*8])
        else $error("drives not released after trip");
    a_start_prompt: assert property (
        $rose(ctrlEnable) && voltage_code_pins != 5'h1F |=> softStartActive)
        else $error("soft start not entered");
    a_disable_abort: assert property (!ctrlEnable |=> !softStartActive &&
        driveOutEn == 4'h0 && softStartCount == 11'h000) else $error("disable not honoured");
    a_count_step: assert property (softStartActive && phaseClkEn && ctrlEnable |=>
        !softStartActive || softStartCount == $past(softStartCount) + 11'h001)
        else $error("soft start count skipped");
    a_code_stop: assert property (voltage_code_pins == 5'h1F |->
        ##[1:2] driveOutEn == 4'h0 && !softStartActive) else $error("off code ignored");
    a_mode_two: assert property (phaseMode == pcv_pkg::MODE_TWO &&
        $past(phaseMode) == pcv_pkg::MODE_TWO |-> driveOutEn[3:2] == 2'h0)
        else $error("unused phases driven");
endmodule
bind pcv_phase_protect pcv_phase_protect_assertions u_chk (.core_clk, .sys_rst, .ctrlEnable,
    .phaseClkEn, .phaseMode, .voltage_code_pins, .driveOutEn, .meanPhaseCurrent,
    .referenceLevel, .codeOff, .softStartActive, .softStartCount, .overCurrent);

// File: testbench/testbench.sv
// Self-checking bench for the protection and code-decode block.
// Assumes the driver model feeds sense; wait count shortened to 16.
`timescale 1ns/10ps
module testbench;
    // ****************************************
    // Stimulus, instances and helpers
    // ****************************************
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ctrlEnable = 1'b0;
    logic phaseClkEn = 1'b0;
    logic [1:0] phaseMode = 2'h0;
    logic [3:0] phaseCycleStart = 4'h0;
    logic [4:0] vcode = 5'h1F;
    logic [11:0] loadUa = 12'h000;
    logic [11:0] skewUa = 12'h000;
    logic [11:0] sense0, sense1, sense2, sense3;
    logic [3:0] driveOutEn;
    logic [11:0] meanPhaseCurrent;
    logic signed [12:0] balanceError;
    logic [10:0] referenceLevel, softStartCount;
    logic codeOff, softStartActive, overCurrent;
    logic [3:0] phaseDrive = 4'hA;
    logic [3:0] driveOut;
    localparam int SEL_SOFT = 0;
    localparam int SEL_TRIP = 1;
    int error_cnt = 0;
    int checks_done = 0;
    int tick = 0;
    int waited;
    always #5 core_clk = ~core_clk;
    // Phase clock every other cycle; conduction starts every eight
    always @(negedge core_clk) begin
        tick = tick + 1;
        phaseClkEn = tick[0];
        phaseCycleStart = (tick % 8 == 0) ? 4'hF : 4'h0;
    end
    pcv_phase_protect #(.WAIT_COUNT(16), .SETTLE(4)) u_dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .ctrlEnable(ctrlEnable), .phaseClkEn(phaseClkEn),
        .phaseMode(phaseMode), .phaseCycleStart(phaseCycleStart),
        .phaseCurrentSense0(sense0), .phaseCurrentSense1(sense1),
        .phaseCurrentSense2(sense2), .phaseCurrentSense3(sense3), .phaseDrive(phaseDrive),
        .voltage_code_pins(vcode), .driveOut(driveOut), .driveOutEn(driveOutEn),
        .meanPhaseCurrent(meanPhaseCurrent), .balanceError(balanceError),
        .referenceLevel(referenceLevel), .codeOff(codeOff),
        .softStartActive(softStartActive), .softStartCount(softStartCount),
        .overCurrent(overCurrent));
    pcv_driver_model u_drv (.driveOutEn(driveOutEn), .loadUa(loadUa), .skewUa(skewUa),
        .sense0(sense0), .sense1(sense1), .sense2(sense2), .sense3(sense3));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Bounded wait at falling edges; running out ends the run
    // Selector picks the watched output, so no reference to a port-driven variable is needed
    task automatic wait_for(input int sel, input logic val, input int lim);
        waited = 0;
        while (((sel == SEL_SOFT) ? softStartActive : overCurrent) !== val) begin
            @(negedge core_clk);
            waited++;
            if (waited > lim) begin
                error_cnt++;
                $display("mismatch at %0t: wait ran out", $time);
                results();
            end
        end
    endtask
    // Every code with the controller held off
    task automatic t_codes();
        for (int c = 0; c < 32; c++) begin
            vcode = 5'(c);
            repeat (2) @(negedge core_clk);
            check(16'(codeOff), 16'(c == 31));
            check(16'(referenceLevel), (c == 31) ? 16'h0000 : 16'h060E - 16'h0019 * 16'(c));
        end
    endtask
    // Start-up, balance in every mode, then the full soft-start length
    task automatic t_start();
        logic [3:0] mask [4] = '{4'hF, 4'h7, 4'h3, 4'hF};
        int n [4] = '{4, 3, 2, 4};
        vcode = 5'h00;
        loadUa = 12'h014;
        skewUa = 12'h004;
        ctrlEnable = 1'b1;
        @(negedge core_clk);
        check(16'(softStartActive), 16'h0001);
        for (int m = 0; m < 4; m++) begin
            phaseMode = 2'(m);
            phaseDrive = ~phaseDrive;
            repeat (40) @(negedge core_clk);
            check(16'(driveOutEn), 16'(mask[m]));
            check(16'(driveOut), 16'(phaseDrive & mask[m]));
            check(16'(meanPhaseCurrent), 16'(20 + 2 * (n[m] - 1)));
            check(16'(balanceError), 16'(-2 * (n[m] - 1)));
        end
        wait_for(SEL_SOFT, 1'b0, 5000);
        check(16'(waited >= 3928 && waited <= 3942), 16'h0001);
        check(16'(driveOutEn), 16'h000F);
        check(16'(driveOut), 16'h000A);
    endtask
    // Persistent overload retries twice, then clears and recovers
    task automatic t_hiccup();
        loadUa = 12'h064;
        skewUa = 12'h000;
        for (int k = 0; k < 2; k++) begin
            wait_for(SEL_TRIP, 1'b1, 40);
            check(16'({softStartActive, driveOutEn}), 16'h0000);
            check(16'(driveOut), 16'h0000);
            wait_for(SEL_SOFT, 1'b1, 60);
            check(16'(waited >= 30 && waited <= 35), 16'h0001);
        end
        wait_for(SEL_TRIP, 1'b1, 40);
        check(16'(softStartActive), 16'h0000);
        loadUa = 12'h014;
        wait_for(SEL_SOFT, 1'b1, 60);
        wait_for(SEL_SOFT, 1'b0, 5000);
        check(16'({overCurrent, driveOutEn}), 16'h000F);
    endtask
    // Disable in mid-hiccup, restart at once, then the off code
    task automatic t_abort();
        loadUa = 12'h064;
        wait_for(SEL_TRIP, 1'b1, 40);
        ctrlEnable = 1'b0;
        repeat (20) @(negedge core_clk);
        check(16'({softStartActive, driveOutEn, softStartCount}), 16'h0000);
        loadUa = 12'h014;
        ctrlEnable = 1'b1;
        @(negedge core_clk);
        check(16'(softStartActive), 16'h0001);
        vcode = 5'h1F;
        repeat (3) @(negedge core_clk);
        check(16'({softStartActive, driveOutEn}), 16'h0000);
        check(16'(driveOut), 16'h0000);
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        t_codes();
        t_start();
        t_hiccup();
        t_abort();
        results();
    end
endmodule
